// ---- common/prm_pkg.sv ----
// Shared constants, types and helpers for the registered read-only memory port
package prm_pkg;

    localparam int WORD_ADDR_W = 9;
    localparam int WORD_DATA_W = 8;
    localparam int WORD_COUNT = 512;
    localparam int LAST_WORD = 511;

    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ALL_ZEROS = 8'h00;
    // Value shown for a never-programmed cell outside blank check
    localparam logic [7:0] ERASED_READ = 8'h00;

    localparam logic SYNC_FF_RESET = 1'b1;
    localparam logic OE_N_RESET = 1'b1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic EDGE_PREV_RESET = 1'b1;

    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_PULSE_US = 100;
    // Least pulse width, rounded up to whole clock cycles
    localparam int PROG_PULSE_CYC = (PROG_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [4:0] {
        MODE_READ    = 5'h01,
        MODE_PROGRAM = 5'h02,
        MODE_VERIFY  = 5'h04,
        MODE_INHIBIT = 5'h08,
        MODE_BLANK   = 5'h10
    } prm_mode_t;

    typedef struct packed {
        logic sync_enable_n;
        logic async_enable_n;
        logic preset_n;
        logic clear_n;
    } prm_ctrl_t;

    typedef struct packed {
        logic program_voltage;
        logic blank_voltage;
        logic program_pulse_n;
        logic verify_strobe;
    } prm_prog_t;

    typedef struct packed {
        logic en;
        logic [WORD_ADDR_W-1:0] addr;
        logic [WORD_DATA_W-1:0] data;
    } prm_wr_t;

    function automatic prm_mode_t prm_decode_mode(input prm_prog_t p);
        prm_mode_t m;
        m = MODE_READ;
        if (p.blank_voltage) begin
            m = MODE_BLANK;
        end else if (p.program_voltage) begin
            if (!p.program_pulse_n && p.verify_strobe) begin
                m = MODE_PROGRAM;
            end else if (p.program_pulse_n && !p.verify_strobe) begin
                m = MODE_VERIFY;
            end else begin
                m = MODE_INHIBIT;
            end
        end
        return m;
    endfunction

    function automatic logic [7:0] prm_blank_fill(input logic strobe);
        return strobe ? ALL_ZEROS : ALL_ONES;
    endfunction

endpackage

// ---- design/prm_array.sv ----
// Nonvolatile word array with per-word programmed flags
module prm_array
    import prm_pkg::*;
#(
    parameter int WORDS = WORD_COUNT,
    parameter int DATA_W = WORD_DATA_W,
    parameter int ADDR_W = WORD_ADDR_W
) (
    input wire logic sys_clk, // system clock
    input wire logic clk_en, // freezes state while low
    input wire logic erase, // clears every programmed flag
    input wire prm_wr_t wr, // programming write
    input wire logic [ADDR_W-1:0] rd_addr, // read address
    output logic [DATA_W-1:0] rd_word, // stored word
    output logic rd_defined // word has been programmed
);
    logic [DATA_W-1:0] mem [WORDS];
    logic [WORDS-1:0] defined_q;

    // Contents survive reset on purpose: the array is nonvolatile
    always_ff @(posedge sys_clk) begin
        if (clk_en && wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            // A write landing in the erase cycle still marks its word
            if (erase) begin
                defined_q <= '0;
            end
            if (wr.en) begin
                defined_q[wr.addr] <= 1'b1;
            end
        end
    end

    assign rd_word = mem[rd_addr];
    assign rd_defined = defined_q[rd_addr];
endmodule

// ---- design/prm_edge.sv ----
// Rising and falling edge detector for a synchronous input level
module prm_edge
    import prm_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic clk_en, // freezes state while low
    input wire logic level, // sampled level
    output logic rise, // high in the cycle the level is first seen high
    output logic fall // high in the cycle the level is first seen low
);
    logic prev;

    // Resetting to high means a level already high at release is no edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev <= EDGE_PREV_RESET;
        end else if (clk_en) begin
            prev <= level;
        end
    end

    assign rise = clk_en && level && !prev;
    assign fall = clk_en && !level && prev;
endmodule

// ---- design/prm_read_port.sv ----
// Registered read port of a 512 x 8 programmable read-only memory
//
// Overview of operation
// (R1) Synchronous-enable flip-flop comes up set, so outputs start high impedance.
// (R2) Array holds 512 words of 8 bits on a 9-bit address.
// (R3) Addressed word loads master stage; clock rise moves it to output slave stage.
// (R4) Asynchronous enable high floats outputs at any time; low restores them. Read mode only here: verify and blank drive regardless.
// (R5) Synchronous enable high floats outputs on the next clock rise.
// (R6) Synchronous enable low reactivates outputs on next clock rise if asynchronous low.
// (R7) Registered output holds until the next clock rise whatever the inputs do, except preset or clear low.
// (R8) Preset low forces master and slave bits to one at once.
// (R9) Clear low forces all register bits to zero at once.
// (R10) Preset or clear value shows only once asynchronous enable is low.
// (R11) Erased cells read as neither one nor zero until programmed.
// (R12) Two blank-check modes expect all ones and all zeros respectively.
// (R13) Programmer reads every location 0 through 511 in each blank mode.
// (R14) Programmer uses 100 us pulses, up to 4, then one long overprogram pulse. Bench host uses PULSE_CYC+1-cycle pulses, PULSE_CYC 4 by default.
// (R15) Programming voltage with read-level controls gives inhibit, outputs high impedance.
// (R16) Preset and clear together: clear wins, register held at zero.
module prm_read_port
    import prm_pkg::*;
#(
    parameter int PROG_PULSE_CYCLES = PROG_PULSE_CYC
) (
    input wire logic sys_clk, // system clock, 125 MHz
    input wire logic reset, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic register_clock, // register clock pin, sampled
    input wire logic [WORD_ADDR_W-1:0] word_address, // word address
    input wire prm_ctrl_t ctrl, // enables, preset and clear
    input wire prm_prog_t prog, // programming pin group
    input wire logic uv_erase, // erases the whole array
    input wire logic [WORD_DATA_W-1:0] data_in, // data pins, input side
    output logic [WORD_DATA_W-1:0] data_out, // data pins, output side
    output logic data_oe_n, // data pins driven while low
    output logic cell_defined // shown word was programmed, or set by preset or clear
);
    localparam int PW_W = $clog2(PROG_PULSE_CYCLES + 1);

    prm_mode_t mode;
    logic clk_rise;
    logic pulse_release;
    logic [WORD_DATA_W-1:0] rd_word;
    logic rd_defined;
    logic [WORD_DATA_W-1:0] master_word;
    logic master_defined;
    logic [WORD_DATA_W-1:0] slave_word;
    logic slave_defined;
    logic sync_ff;
    logic [PW_W-1:0] pulse_cnt;
    prm_wr_t wr;
    logic next_drive;
    logic [WORD_DATA_W-1:0] next_data;
    logic next_defined;
    logic clear_hold;
    logic force_zero;

    assign mode = prm_decode_mode(prog);

    prm_edge u_clk_edge (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(register_clock),
        .rise(clk_rise),
        .fall()
    );

    prm_edge u_pulse_edge (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .level(prog.program_pulse_n),
        .rise(pulse_release),
        .fall()
    );

    prm_array u_array ( // see (R2)
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .erase(uv_erase),
        .wr(wr),
        .rd_addr(word_address),
        .rd_word(rd_word),
        .rd_defined(rd_defined)
    );

    // Width of the current program pulse, saturating
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pulse_cnt <= '0;
        end else if (clk_en) begin
            if (mode == MODE_PROGRAM) begin
                if (pulse_cnt < PW_W'(PROG_PULSE_CYCLES)) begin
                    pulse_cnt <= pulse_cnt + PW_W'(1);
                end
            end else if (!pulse_release) begin
                pulse_cnt <= '0;
            end
        end
    end

    // A pulse that ends too short leaves the cell as it was
    always_comb begin
        wr.en = pulse_release && prog.program_voltage && !prog.blank_voltage
            && (pulse_cnt >= PW_W'(PROG_PULSE_CYCLES));
        wr.addr = word_address;
        wr.data = data_in;
    end

    // Both initialize inputs low keep clear in force until preset is released too
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clear_hold <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl.clear_n && !ctrl.preset_n) begin // see (R16)
                clear_hold <= 1'b1;
            end else if (ctrl.preset_n) begin
                clear_hold <= 1'b0;
            end
        end
    end

    assign force_zero = !ctrl.clear_n || (clear_hold && !ctrl.preset_n);

    // Master stage follows the address every cycle; clear beats preset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            master_word <= DATA_RESET;
            master_defined <= 1'b0;
        end else if (clk_en) begin
            if (force_zero) begin // see (R9) see (R16)
                master_word <= ALL_ZEROS;
                master_defined <= 1'b1;
            end else if (!ctrl.preset_n) begin // see (R8)
                master_word <= ALL_ONES;
                master_defined <= 1'b1;
            end else begin // see (R3) see (R11)
                master_word <= rd_defined ? rd_word : ERASED_READ;
                master_defined <= rd_defined;
            end
        end
    end

    // Slave stage changes only on a register clock rise or an initialize
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            slave_word <= DATA_RESET;
            slave_defined <= 1'b0;
        end else if (clk_en) begin
            if (force_zero) begin // see (R9) see (R16)
                slave_word <= ALL_ZEROS;
                slave_defined <= 1'b1;
            end else if (!ctrl.preset_n) begin // see (R8)
                slave_word <= ALL_ONES;
                slave_defined <= 1'b1;
            end else if (clk_rise && mode == MODE_READ) begin // see (R3) see (R7)
                slave_word <= master_word;
                slave_defined <= master_defined;
            end
        end
    end

    // Initialize inputs do not touch the enable flip-flop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync_ff <= SYNC_FF_RESET; // see (R1)
        end else if (clk_en && clk_rise && mode == MODE_READ) begin
            sync_ff <= ctrl.sync_enable_n; // see (R5) see (R6)
        end
    end

    always_comb begin
        next_drive = 1'b0;
        next_data = slave_word;
        next_defined = slave_defined;
        case (mode)
            MODE_READ: begin
                // see (R4) see (R5) see (R6) see (R10)
                next_drive = !sync_ff && !ctrl.async_enable_n;
            end
            MODE_VERIFY: begin
                next_drive = 1'b1;
                next_data = rd_defined ? rd_word : ERASED_READ; // see (R11)
                next_defined = rd_defined;
            end
            MODE_BLANK: begin
                next_drive = 1'b1;
                next_data = rd_defined ? rd_word : prm_blank_fill(prog.verify_strobe); // see (R12)
                next_defined = rd_defined;
            end
            default: begin
                next_drive = 1'b0; // see (R15)
            end
        endcase
    end

    // Pins are registered: enable and verify effects trail their cause by one cycle, clock rises and initializes by two
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_oe_n <= OE_N_RESET; // see (R1)
            data_out <= DATA_RESET;
            cell_defined <= 1'b0;
        end else if (clk_en) begin
            data_oe_n <= !next_drive;
            data_out <= next_data;
            cell_defined <= next_defined;
        end
    end

    property p_powerup_float;
        @(posedge sys_clk) disable iff (!clk_en)
        $fell(reset) |-> data_oe_n ##1 data_oe_n;
    endproperty
    a_powerup_float: assert property (p_powerup_float) // see (R1)
        else $error("outputs not floating after reset");

    property p_slave_load;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (clk_rise && mode == MODE_READ && ctrl.preset_n && ctrl.clear_n)
            |=> slave_word == $past(master_word);
    endproperty
    a_slave_load: assert property (p_slave_load) // see (R3)
        else $error("slave did not take master on clock rise");

    property p_async_float;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (mode == MODE_READ && ctrl.async_enable_n) |=> data_oe_n;
    endproperty
    a_async_float: assert property (p_async_float) // see (R4)
        else $error("outputs driven with asynchronous enable high");

    property p_sync_off;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (clk_rise && mode == MODE_READ && ctrl.sync_enable_n) |=> ##1 data_oe_n;
    endproperty
    a_sync_off: assert property (p_sync_off) // see (R5)
        else $error("outputs not floated after synchronous disable");

    property p_sync_on;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (clk_rise && mode == MODE_READ && !ctrl.sync_enable_n)
            ##1 (mode == MODE_READ && !ctrl.async_enable_n) |=> !data_oe_n;
    endproperty
    a_sync_on: assert property (p_sync_on) // see (R6)
        else $error("outputs not driven after synchronous enable");

    property p_hold;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (!clk_rise && ctrl.preset_n && ctrl.clear_n) |=> $stable(slave_word);
    endproperty
    a_hold: assert property (p_hold) // see (R7)
        else $error("registered word changed without clock rise");

    property p_preset;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (!ctrl.preset_n && ctrl.clear_n && !clear_hold)
            |=> (slave_word == ALL_ONES && master_word == ALL_ONES);
    endproperty
    a_preset: assert property (p_preset) // see (R8)
        else $error("preset did not force ones");

    property p_clear;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        !ctrl.clear_n |=> (slave_word == ALL_ZEROS && master_word == ALL_ZEROS);
    endproperty
    a_clear: assert property (p_clear) // see (R9) see (R16)
        else $error("clear did not force zeros");

    property p_clear_hold;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (!ctrl.clear_n && !ctrl.preset_n) ##1 (ctrl.clear_n && !ctrl.preset_n)
            |=> (slave_word == ALL_ZEROS && master_word == ALL_ZEROS);
    endproperty
    a_clear_hold: assert property (p_clear_hold) // see (R16)
        else $error("register left zero before both initialize inputs released");

    // Enable low must freeze the pins even while the controls move
    property p_freeze;
        @(posedge sys_clk) disable iff (reset)
        !clk_en |=> ($stable(data_out) && $stable(data_oe_n) && $stable(slave_word));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_init_shown;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (!ctrl.clear_n && mode == MODE_READ && !sync_ff && !ctrl.async_enable_n)
            ##1 (mode == MODE_READ && !ctrl.async_enable_n && ctrl.preset_n)
            |=> (!data_oe_n && data_out == ALL_ZEROS);
    endproperty
    a_init_shown: assert property (p_init_shown) // see (R10)
        else $error("cleared value not shown when enabled");

    property p_blank_ones;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (mode == MODE_BLANK && !prog.verify_strobe && !rd_defined)
            |=> (!data_oe_n && data_out == ALL_ONES && !cell_defined);
    endproperty
    a_blank_ones: assert property (p_blank_ones) // see (R12)
        else $error("blank ones check wrong for erased cell");

    property p_inhibit;
        @(posedge sys_clk) disable iff (reset || !clk_en)
        (mode == MODE_INHIBIT || mode == MODE_PROGRAM) |=> data_oe_n;
    endproperty
    a_inhibit: assert property (p_inhibit) // see (R15)
        else $error("outputs driven in program or inhibit mode");

    c_read_active: cover property (@(posedge sys_clk) disable iff (reset)
        $fell(data_oe_n) && mode == MODE_READ);
    c_preset: cover property (@(posedge sys_clk) disable iff (reset)
        !ctrl.preset_n && ctrl.clear_n);
    c_program_write: cover property (@(posedge sys_clk) disable iff (reset) wr.en);
    c_blank_zeros: cover property (@(posedge sys_clk) disable iff (reset)
        mode == MODE_BLANK && prog.verify_strobe && !rd_defined);
endmodule

// ---- testbench/prm_host_model.sv ----
// Host model: sequencer and programmer driving the read port pins
module prm_host_model
    import prm_pkg::*;
#(
    parameter int PULSE_CYC = 4
) (
    input wire logic sys_clk, // system clock
    input wire logic [WORD_DATA_W-1:0] pin_data, // resolved data pins
    input wire logic data_oe_n, // device drives the pins while low
    output logic register_clock, // register clock pin
    output logic [WORD_ADDR_W-1:0] word_address, // word address
    output prm_ctrl_t ctrl, // enables, preset and clear
    output prm_prog_t prog, // programming pin group
    output logic uv_erase, // array erase
    output logic [WORD_DATA_W-1:0] host_data, // value the host puts on the pins
    output logic host_drive // host drives the data pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        register_clock = 1'b0;
        word_address = 9'h000;
        ctrl = '{1'b1, 1'b1, 1'b1, 1'b1};
        prog = '{1'b0, 1'b0, 1'b1, 1'b0};
        uv_erase = 1'b0;
        host_data = 8'h00;
        host_drive = 1'b0;
    end

    // Pins only change on the falling edge, clear of the sampling edge
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic set_ctrl(input prm_ctrl_t c);
        step(1);
        ctrl = c;
    endtask

    task automatic set_prog(input prm_prog_t p);
        step(1);
        prog = p;
    endtask

    task automatic set_addr(input logic [8:0] a);
        step(1);
        word_address = a;
    endtask

    task automatic erase();
        step(1);
        uv_erase = 1'b1;
        step(1);
        uv_erase = 1'b0;
    endtask

    // Address settles one sample before the rise; returns once outputs settled
    task automatic clock_word(input logic [8:0] a);
        step(1);
        word_address = a;
        register_clock = 1'b0;
        step(1);
        register_clock = 1'b1;
        step(3);
        register_clock = 1'b0;
    endtask

    // One pulse, then a verify read of the pins
    task automatic pulse_verify(input int cyc, output logic [7:0] got);
        step(1);
        prog = '{1'b1, 1'b0, 1'b0, 1'b1};
        step(cyc + 1);
        prog.program_pulse_n = 1'b1;
        step(1);
        prog.verify_strobe = 1'b0;
        host_drive = 1'b0;
        step(2);
        got = pin_data;
        prog.verify_strobe = 1'b1;
    endtask

    task automatic program_word(input logic [8:0] a, input logic [7:0] d, output int tries);
        logic [7:0] got;
        step(1);
        word_address = a;
        host_data = d;
        prog = '{1'b1, 1'b0, 1'b1, 1'b1};
        tries = 0;
        got = ~d;
        while (tries < 4 && got !== d) begin
            tries++;
            host_drive = 1'b1;
            pulse_verify(PULSE_CYC, got);
        end
        if (got === d) begin
            host_drive = 1'b1;
            pulse_verify(24 * tries * PULSE_CYC, got);
        end
        step(1);
        host_drive = 1'b0;
        prog = '{1'b0, 1'b0, 1'b1, 1'b0};
    endtask

    // Walks every location in one blank mode and counts words off the fill
    task automatic blank_check(input logic zeros, output int misses);
        logic [7:0] want;
        want = zeros ? ALL_ZEROS : ALL_ONES;
        misses = 0;
        step(1);
        prog = '{1'b0, 1'b1, 1'b1, zeros};
        for (int a = 0; a <= LAST_WORD; a++) begin
            word_address = a[8:0];
            step(2);
            if (pin_data !== want || data_oe_n !== 1'b0) misses++;
        end
        prog = '{1'b0, 1'b0, 1'b1, 1'b0};
    endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the registered read-only memory port
module tb
    import prm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 4;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic register_clock, uv_erase, data_oe_n, cell_defined, host_drive;
    logic [WORD_ADDR_W-1:0] word_address;
    logic [WORD_DATA_W-1:0] data_out, host_data, pin_data;
    prm_ctrl_t ctrl;
    prm_prog_t prog;
    int bad_count = 0;
    int total_checks = 0;
    int n;

    // Released pins show the host value while the host drives, else its inverse, never a stale copy
    assign pin_data = !data_oe_n ? data_out : (host_drive ? host_data : ~host_data);

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    prm_host_model #(.PULSE_CYC(PULSE)) u_host (
        .sys_clk(sys_clk), .pin_data(pin_data), .data_oe_n(data_oe_n),
        .register_clock(register_clock), .word_address(word_address), .ctrl(ctrl),
        .prog(prog), .uv_erase(uv_erase), .host_data(host_data), .host_drive(host_drive)
    );

    prm_read_port #(.PROG_PULSE_CYCLES(PULSE)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .register_clock(register_clock),
        .word_address(word_address), .ctrl(ctrl), .prog(prog), .uv_erase(uv_erase),
        .data_in(pin_data), .data_out(data_out), .data_oe_n(data_oe_n),
        .cell_defined(cell_defined)
    );

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Saturates a count so that 256 misses cannot wrap to zero
    function automatic logic [7:0] sat8(input int v);
        return (v > 255) ? 8'hFF : v[7:0];
    endfunction

    task automatic look(input string what, input logic [7:0] d, input logic def);
        check({what, " data"}, d, data_out);
        check({what, " enable"}, 8'h00, {7'h00, data_oe_n});
        check({what, " defined"}, {7'h00, def}, {7'h00, cell_defined});
    endtask

    task automatic t_reset();
        check("reset enable", 8'h01, {7'h00, data_oe_n});
        check("reset data", DATA_RESET, data_out);
    endtask

    task automatic t_blank_erased();
        u_host.erase();
        u_host.blank_check(1'b0, n);
        check("blank ones misses", 8'h00, sat8(n));
        u_host.blank_check(1'b1, n);
        check("blank zeros misses", 8'h00, sat8(n));
    endtask

    task automatic t_program_read();
        logic [8:0] a[3] = '{9'h000, 9'h100, 9'h1FF};
        logic [7:0] d[3] = '{8'hA5, 8'h81, 8'h3C};
        for (int i = 0; i < 3; i++) begin
            u_host.program_word(a[i], d[i], n);
            check("program attempts", 8'h01, sat8(n));
        end
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        for (int i = 0; i < 3; i++) begin
            u_host.clock_word(a[i]);
            look("read", d[i], 1'b1);
        end
        u_host.clock_word(9'h007);
        look("erased", ERASED_READ, 1'b0);
        u_host.blank_check(1'b0, n);
        check("blank ones after program", 8'h03, sat8(n));
    endtask

    task automatic t_hold_sync();
        u_host.clock_word(9'h000);
        u_host.set_addr(9'h1FF);
        u_host.set_ctrl('{1'b1, 1'b0, 1'b1, 1'b1});
        u_host.step(4);
        look("hold", 8'hA5, 1'b1);
        u_host.clock_word(9'h1FF);
        check("sync float", 8'h01, {7'h00, data_oe_n});
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        u_host.clock_word(9'h1FF);
        look("sync restore", 8'h3C, 1'b1);
    endtask

    task automatic t_async();
        u_host.set_ctrl('{1'b0, 1'b1, 1'b1, 1'b1});
        u_host.step(2);
        check("async float", 8'h01, {7'h00, data_oe_n});
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        u_host.step(2);
        look("async restore", 8'h3C, 1'b1);
    endtask

    // Enable low: a clock rise and an async disable must both be ignored
    task automatic t_freeze();
        u_host.step(1);
        clk_en = 1'b0;
        u_host.set_ctrl('{1'b0, 1'b1, 1'b1, 1'b1});
        u_host.clock_word(9'h000);
        look("frozen", 8'h3C, 1'b1);
        u_host.step(1);
        clk_en = 1'b1;
        u_host.step(2);
        check("thawed float", 8'h01, {7'h00, data_oe_n});
        check("thawed data", 8'h3C, data_out);
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        u_host.step(2);
    endtask

    task automatic t_init();
        u_host.set_ctrl('{1'b0, 1'b1, 1'b0, 1'b1});
        u_host.step(3);
        check("preset hidden", 8'h01, {7'h00, data_oe_n});
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        u_host.step(2);
        look("preset", ALL_ONES, 1'b1);
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b0});
        u_host.step(2);
        look("clear", ALL_ZEROS, 1'b1);
        u_host.set_ctrl('{1'b0, 1'b0, 1'b0, 1'b0});
        u_host.step(2);
        look("both", ALL_ZEROS, 1'b1);
        u_host.set_ctrl('{1'b0, 1'b0, 1'b0, 1'b1});
        u_host.step(2);
        look("clear held", ALL_ZEROS, 1'b1);
        u_host.set_ctrl('{1'b0, 1'b0, 1'b1, 1'b1});
        u_host.step(2);
        look("both released", ALL_ZEROS, 1'b1);
    endtask

    task automatic t_inhibit();
        u_host.set_prog('{1'b1, 1'b0, 1'b1, 1'b1});
        u_host.step(2);
        check("inhibit float", 8'h01, {7'h00, data_oe_n});
        u_host.set_prog('{1'b0, 1'b0, 1'b1, 1'b0});
        u_host.step(2);
        check("read driven", 8'h00, {7'h00, data_oe_n});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        stop_test();
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        u_host.step(1);
        t_reset();
        t_blank_erased();
        t_program_read();
        t_hold_sync();
        t_async();
        t_freeze();
        t_init();
        t_inhibit();
        stop_test();
    end
endmodule
